/* verilog/wdrc_top.sv */
/*
 * Watchdog timer with keyed enable and reset-source control.
 * Assumes slow_tick_in is a one-cycle pulse per slow oscillator period,
 * and that power-on is srst_in; other resets are issued on outputs.
 */
// How it works
// - select code picks 2^8..2^18 timeout
// - key 10101 disables, 01010 enables watchdog
// - bad key resets device after delay
// - bad key sets flag bit 0
// - key flag cleared only by software zero or power-on
// - power-on key 01010, select 011
// - running overflow resets device, sets timeout
// - sleep overflow sets timeout, resets pc/sp
// - count cleared by key reset, clear, halt, pin
// - 0x55 selects I/O, 0xAA reset pin
// - bad pin code resets after delay
// - pin control powers on as 0x55
// - power-on clears program counter
// - power-on presets ports high as inputs
// - low reset pin resets, clears pc
// - extra delay after pin release
// - pin reset keeps some registers
// - undervoltage reset acts like pin reset but sets flag bit 2 and does not clear count
// - halt clears watchdog, sets powerdown, clears timeout
// - non-watchdog resets restore pin control
`timescale 1ns/1ps

module wdrc_top #(
    parameter int SOFT_CYCLES = wdrc_pkg::SOFT_RESET_CYCLES,
    parameter int RELEASE_CYCLES = wdrc_pkg::RELEASE_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Core events
    input wire logic slow_tick_in,
    input wire logic clear_watchdog_in,
    input wire logic halt_in,
    input wire logic wake_in,
    input wire logic undervoltage_reset_in,
    input wire logic external_reset_pin_n_in,
    // Reset outputs
    output logic device_reset_out,
    output logic pc_sp_reset_out,
    output logic port_preset_out,
    output logic pin_is_reset_out,
    output logic sleeping_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        WDRC_RUN = 3'b001,
        WDRC_SOFT_WAIT = 3'b010,
        WDRC_PIN_HOLD = 3'b100
    } wdrc_state_t;

    wdrc_state_t state_reg;
    logic [4:0] wdt_enable_key_reg;
    logic [2:0] wdt_timeout_select_reg;
    logic [7:0] reset_pin_select_key_reg;
    logic [3:0] flags_reg;
    logic timeout_status_flag_reg;
    logic powerdown_status_flag_reg;
    logic [wdrc_pkg::WDT_W-1:0] wdt_count_reg;
    logic sleep_reg;
    logic soft_pending_reg;
    logic wdt_key_bad_reg;
    logic pin_key_bad_reg;

    logic wr_wdt;
    logic wr_cause;
    logic wr_pin;
    logic wdt_enabled;
    logic pin_low;
    logic overflow;
    logic soft_start;
    logic soft_done;
    logic soft_busy;
    logic rel_start;
    logic rel_done;
    logic rel_busy;
    logic full_reset;
    logic [wdrc_pkg::WDT_W-1:0] limit;

    assign wr_wdt = reg_write_in && (reg_addr_in == wdrc_pkg::OFS_WDT_CTRL);
    assign wr_cause = reg_write_in && (reg_addr_in == wdrc_pkg::OFS_CAUSE);
    assign wr_pin = reg_write_in && (reg_addr_in == wdrc_pkg::OFS_PIN_CTRL);
    assign wdt_enabled = (wdt_enable_key_reg == wdrc_pkg::KEY_ENABLE);
    assign pin_low = pin_is_reset_out && !external_reset_pin_n_in;

    // ------------------------------------------------------------------
    // Timeout length
    // ------------------------------------------------------------------
    always_comb begin
        case (wdt_timeout_select_reg)
            3'h0: limit = 18'h0_00ff;
            3'h1: limit = 18'h0_03ff;
            3'h2: limit = 18'h0_0fff;
            3'h3: limit = 18'h0_3fff;
            3'h4: limit = 18'h0_7fff;
            3'h5: limit = 18'h0_ffff;
            3'h6: limit = 18'h1_ffff;
            default: limit = 18'h3_ffff;
        endcase
    end

    assign overflow = wdt_enabled && slow_tick_in && (wdt_count_reg >= limit)
        && (state_reg == WDRC_RUN);

    // A full reset restores key, select, pin control and sleep; flags, status and the watchdog warm reset path are left alone
    assign full_reset = soft_done || pin_low || undervoltage_reset_in;

    // ------------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------------
    assign soft_start = soft_pending_reg && (state_reg == WDRC_RUN);
    // Undervoltage holds the release delay off too; the done cycle must not retrigger it
    assign rel_start = (state_reg == WDRC_PIN_HOLD) && !pin_low && !undervoltage_reset_in
        && !rel_busy && !rel_done;

    wdrc_delay #(
        .WIDTH(wdrc_pkg::DELAY_W)
    ) u_soft_delay (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .start_in(soft_start),
        .cycles_in(SOFT_CYCLES[wdrc_pkg::DELAY_W-1:0]),
        .busy_out(soft_busy),
        .done_out(soft_done)
    );

    wdrc_delay #(
        .WIDTH(wdrc_pkg::DELAY_W)
    ) u_release_delay (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .start_in(rel_start),
        .cycles_in(RELEASE_CYCLES[wdrc_pkg::DELAY_W-1:0]),
        .busy_out(rel_busy),
        .done_out(rel_done)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= WDRC_RUN;
        end else begin
            case (state_reg)
                WDRC_RUN: begin
                    if (pin_low || undervoltage_reset_in) begin
                        state_reg <= WDRC_PIN_HOLD;
                    end else if (soft_start) begin
                        state_reg <= WDRC_SOFT_WAIT;
                    end
                end
                WDRC_SOFT_WAIT: begin
                    if (soft_done) begin
                        state_reg <= WDRC_PIN_HOLD;
                    end
                end
                WDRC_PIN_HOLD: begin
                    if (pin_low || undervoltage_reset_in) begin
                        state_reg <= WDRC_PIN_HOLD;
                    end else if (rel_done) begin
                        state_reg <= WDRC_RUN;
                    end
                end
                default: state_reg <= WDRC_RUN;
            endcase
        end
    end

    // Soft reset request latches on a bad key and waits for the delay
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            soft_pending_reg <= 1'b0;
            wdt_key_bad_reg <= 1'b0;
            pin_key_bad_reg <= 1'b0;
        end else if (soft_done) begin
            soft_pending_reg <= 1'b0;
            wdt_key_bad_reg <= 1'b0;
            pin_key_bad_reg <= 1'b0;
        end else begin
            if (wr_wdt && reg_wdata_in[7:wdrc_pkg::KEY_LSB] != wdrc_pkg::KEY_ENABLE
                && reg_wdata_in[7:wdrc_pkg::KEY_LSB] != wdrc_pkg::KEY_DISABLE) begin
                soft_pending_reg <= 1'b1;
                wdt_key_bad_reg <= 1'b1;
            end
            if (wr_pin && reg_wdata_in != wdrc_pkg::PIN_IS_IO
                && reg_wdata_in != wdrc_pkg::PIN_IS_RESET) begin
                soft_pending_reg <= 1'b1;
                pin_key_bad_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in || full_reset) begin
            wdt_enable_key_reg <= wdrc_pkg::KEY_ENABLE;
            wdt_timeout_select_reg <= wdrc_pkg::SEL_POR;
        end else if (wr_wdt) begin
            wdt_enable_key_reg <= reg_wdata_in[7:wdrc_pkg::KEY_LSB];
            wdt_timeout_select_reg <= reg_wdata_in[wdrc_pkg::SEL_MSB:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || full_reset) begin
            reset_pin_select_key_reg <= wdrc_pkg::PIN_IS_IO;
        end else if (wr_pin) begin
            reset_pin_select_key_reg <= reg_wdata_in;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            flags_reg <= 4'h0;
        end else begin
            if (wr_cause) begin
                flags_reg <= flags_reg & reg_wdata_in[3:0];
            end
            if (soft_done && wdt_key_bad_reg) begin
                flags_reg[wdrc_pkg::FLAG_WDT_KEY] <= 1'b1;
            end
            if (soft_done && pin_key_bad_reg) begin
                flags_reg[wdrc_pkg::FLAG_PIN_KEY] <= 1'b1;
            end
            if (undervoltage_reset_in) begin
                flags_reg[wdrc_pkg::FLAG_UNDERVOLT] <= 1'b1;
            end
        end
    end

    // Status flags: pin and undervoltage resets leave them unchanged
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            timeout_status_flag_reg <= 1'b0;
            powerdown_status_flag_reg <= 1'b0;
        end else if (overflow) begin
            timeout_status_flag_reg <= 1'b1;
        end else if (halt_in) begin
            timeout_status_flag_reg <= 1'b0;
            powerdown_status_flag_reg <= 1'b1;
        end else if (clear_watchdog_in) begin
            timeout_status_flag_reg <= 1'b0;
            powerdown_status_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in || full_reset) begin
            sleep_reg <= 1'b0;
        end else if (halt_in) begin
            sleep_reg <= 1'b1;
        end else if (wake_in || overflow) begin
            sleep_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in || soft_done || pin_low || clear_watchdog_in || halt_in) begin
            wdt_count_reg <= '0;
        end else if (overflow) begin
            wdt_count_reg <= '0;
        end else if (wdt_enabled && slow_tick_in) begin
            wdt_count_reg <= wdt_count_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            device_reset_out <= 1'b1;
            pc_sp_reset_out <= 1'b1;
            port_preset_out <= 1'b1;
        end else begin
            device_reset_out <= (state_reg == WDRC_PIN_HOLD) || full_reset
                || (overflow && !sleep_reg);
            pc_sp_reset_out <= (state_reg == WDRC_PIN_HOLD) || full_reset
                || overflow;
            port_preset_out <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin_is_reset_out <= 1'b0;
            sleeping_out <= 1'b0;
        end else begin
            pin_is_reset_out <= (reset_pin_select_key_reg == wdrc_pkg::PIN_IS_RESET);
            sleeping_out <= sleep_reg;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (!reg_read_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in == wdrc_pkg::OFS_WDT_CTRL) begin
            reg_rdata_out <= {wdt_enable_key_reg, wdt_timeout_select_reg};
        end else if (reg_addr_in == wdrc_pkg::OFS_CAUSE) begin
            reg_rdata_out <= {4'h0, flags_reg};
        end else if (reg_addr_in == wdrc_pkg::OFS_PIN_CTRL) begin
            reg_rdata_out <= reset_pin_select_key_reg;
        end else if (reg_addr_in == wdrc_pkg::OFS_STATUS) begin
            reg_rdata_out <= {6'h00, powerdown_status_flag_reg, timeout_status_flag_reg};
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

endmodule // wdrc_top

/* include/wdrc_pkg.sv */
/*
 * Package for the watchdog and reset control block: register offsets,
 * field positions, key codes, reset values and timing counts.
 * Assumes a 40 MHz system clock and a slow oscillator tick input.
 */
package wdrc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_WDT_CTRL = 4'h0;
    localparam logic [3:0] OFS_CAUSE = 4'h1;
    localparam logic [3:0] OFS_PIN_CTRL = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;

    // ------------------------------------------------------------------
    // Field positions and key codes
    // ------------------------------------------------------------------
    localparam int KEY_LSB = 3;
    localparam int SEL_MSB = 2;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE = 5'h0a;
    localparam logic [2:0] SEL_POR = 3'h3;
    localparam logic [7:0] PIN_IS_IO = 8'h55;
    localparam logic [7:0] PIN_IS_RESET = 8'haa;

    localparam int FLAG_WDT_KEY = 0;
    localparam int FLAG_VSEL_KEY = 1;
    localparam int FLAG_UNDERVOLT = 2;
    localparam int FLAG_PIN_KEY = 3;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_POWERDOWN = 1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int SOFT_RESET_DELAY_US = 50;
    localparam int RELEASE_DELAY_US = 100;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_DELAY_US * CLK_MHZ;
    localparam int RELEASE_CYCLES = RELEASE_DELAY_US * CLK_MHZ;
    localparam int DELAY_W = 16;
    localparam int WDT_W = 18;

endpackage

/* verilog/wdrc_delay.sv */
/*
 * Down counter that raises done after a loaded number of cycles.
 * Assumes load and the count are synchronous to clock_in.
 */
`timescale 1ns/1ps

module wdrc_delay #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Control
    input wire logic start_in,
    input wire logic [WIDTH-1:0] cycles_in,
    // Status
    output logic busy_out,
    output logic done_out
);

    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            count_reg <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                count_reg <= cycles_in;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (count_reg <= 1) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // wdrc_delay

/* bench/wdrc_top_asserts.sv */
/* Port checker for wdrc_top.
   Assumes it is bound to wdrc_top and sees only that module's ports. */
`timescale 1ns/1ps
module wdrc_top_asserts #(
    parameter int SOFT_CYCLES = 4,
    parameter int RELEASE_CYCLES = 6
) (
    // Watched ports
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic halt_in,
    input wire logic wake_in,
    input wire logic undervoltage_reset_in,
    input wire logic external_reset_pin_n_in,
    input wire logic device_reset_out,
    input wire logic port_preset_out,
    input wire logic pin_is_reset_out,
    input wire logic sleeping_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence pin_key_write;
        reg_write_in && reg_addr_in == wdrc_pkg::OFS_PIN_CTRL
            && reg_wdata_in == wdrc_pkg::PIN_IS_RESET && !device_reset_out;
    endsequence
    // Quiet surroundings only, so no other reset source hides the delay
    sequence bad_key_write;
        reg_write_in && reg_addr_in == wdrc_pkg::OFS_WDT_CTRL
            && reg_wdata_in[7:3] != wdrc_pkg::KEY_ENABLE
            && reg_wdata_in[7:3] != wdrc_pkg::KEY_DISABLE && !device_reset_out
            && !undervoltage_reset_in && external_reset_pin_n_in;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rdata_idle_zero: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_reads_zero: assert property ($past(reg_read_in) && $past(reg_addr_in) > 4'h3
        |-> reg_rdata_out == 8'h00) else $error("unmapped index read not zero");
    a_flags_upper_zero: assert property ($past(reg_read_in)
        && $past(reg_addr_in) == wdrc_pkg::OFS_CAUSE |-> reg_rdata_out[7:4] == 4'h0)
        else $error("unused flag bits not zero");
    a_preset_after_release: assert property (!$past(srst_in) |-> !port_preset_out)
        else $error("port preset outside power-on reset");
    a_bad_key_delay: assert property (bad_key_write |=> !device_reset_out [*4])
        else $error("bad key reset came without delay");
    a_pin_select_on: assert property (pin_key_write |-> ##[1:2] pin_is_reset_out)
        else $error("reset pin function not selected");
    a_pin_reset_act: assert property (pin_is_reset_out && !external_reset_pin_n_in
        |-> ##[1:2] device_reset_out) else $error("low reset pin gave no reset");
    a_uv_reset_act: assert property (undervoltage_reset_in |-> ##[0:2] device_reset_out)
        else $error("undervoltage gave no reset");
    a_halt_enters_sleep: assert property (halt_in && !device_reset_out
        |-> ##[1:2] sleeping_out) else $error("halt did not enter sleep");
    a_wake_leaves_sleep: assert property (sleeping_out && wake_in |-> ##[1:2] !sleeping_out)
        else $error("wake did not leave sleep");
endmodule // wdrc_top_asserts

bind wdrc_top wdrc_top_asserts #(
    .SOFT_CYCLES(SOFT_CYCLES),
    .RELEASE_CYCLES(RELEASE_CYCLES)
) wdrc_top_asserts_inst (
    .clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .halt_in(halt_in), .wake_in(wake_in),
    .undervoltage_reset_in(undervoltage_reset_in),
    .external_reset_pin_n_in(external_reset_pin_n_in), .device_reset_out(device_reset_out),
    .port_preset_out(port_preset_out), .pin_is_reset_out(pin_is_reset_out),
    .sleeping_out(sleeping_out)
);

/* bench/tb_wdrc_top.sv */
/* Self-checking bench for wdrc_top with a register model in integers.
   Assumes short soft and release delays set by parameter for speed. */
`timescale 1ns/1ps
module tb_wdrc_top;
    logic clock_in = 1'b0, srst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
    logic slow_tick_in = 1'b0, clear_watchdog_in = 1'b0, halt_in = 1'b0, wake_in = 1'b0;
    logic undervoltage_reset_in = 1'b0, external_reset_pin_n_in = 1'b1;
    logic device_reset_out, pc_sp_reset_out, port_preset_out, pin_is_reset_out, sleeping_out;
    int miscompares = 0, samples_checked = 0, dev_hi = 0, pcsp_hi = 0;
    int m_ctrl, m_pin, m_flags, m_status, n, d0, p0, v, len;

    always #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        if (device_reset_out === 1'b1) dev_hi++;
        if (pc_sp_reset_out === 1'b1) pcsp_hi++;
    end

    wdrc_top #(.SOFT_CYCLES(4), .RELEASE_CYCLES(6)) wdrc_top_inst (
        .clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .slow_tick_in(slow_tick_in),
        .clear_watchdog_in(clear_watchdog_in), .halt_in(halt_in), .wake_in(wake_in),
        .undervoltage_reset_in(undervoltage_reset_in),
        .external_reset_pin_n_in(external_reset_pin_n_in), .device_reset_out(device_reset_out),
        .pc_sp_reset_out(pc_sp_reset_out), .port_preset_out(port_preset_out),
        .pin_is_reset_out(pin_is_reset_out), .sleeping_out(sleeping_out));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_addr_in <= a; reg_wdata_in <= d; reg_write_in <= 1'b1;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input int e);
        @(posedge clock_in);
        reg_addr_in <= a; reg_read_in <= 1'b1;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        #1 chk(reg_rdata_out, e[7:0]);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clock_in);
            slow_tick_in <= 1'b1;
        end
        @(posedge clock_in);
        slow_tick_in <= 1'b0;
    endtask
    // 0 clear instruction, 1 halt, 2 wake
    task automatic ev(input int w);
        @(posedge clock_in);
        clear_watchdog_in <= (w == 0); halt_in <= (w == 1); wake_in <= (w == 2);
        @(posedge clock_in);
        clear_watchdog_in <= 1'b0; halt_in <= 1'b0; wake_in <= 1'b0;
    endtask
    task automatic wait_lvl(input logic lvl, output int k);
        k = 0;
        while (device_reset_out !== lvl && k < 100) begin
            @(posedge clock_in);
            #1 k++;
        end
        chk({7'h0, device_reset_out}, {7'h0, lvl});
    endtask

    initial begin
        repeat (90000) @(posedge clock_in);
        miscompares++;
        test_done();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(87));
        repeat (20) @(posedge clock_in);
        srst_in <= 1'b0;
        #1 chk({7'h0, port_preset_out}, 8'h01);
        m_ctrl = 8'h53; m_pin = 8'h55; m_flags = 0; m_status = 0;
        rd(0, m_ctrl);
        rd(1, m_flags);
        rd(2, m_pin);
        rd(3, m_status);
        for (int i = 0; i < 4; i++) begin
            v = 4 + $urandom_range(0, 11);
            wr(v[3:0], 8'($urandom));
            rd(v[3:0], 0);
        end
        rd(0, m_ctrl);
        // Disabled watchdog must never expire
        m_ctrl = 8'ha8;
        wr(0, 8'ha8);
        ev(0);
        p0 = pcsp_hi;
        ticks(300);
        idle(3);
        chk(8'(pcsp_hi - p0), 0);
        rd(0, m_ctrl);
        // Overflow length for select codes 0 to 4; the first also proves clear restarts
        for (int c = 0; c < 5; c++) begin
            len = (c < 4) ? (1 << (8 + 2 * c)) : (1 << (11 + c));
            m_ctrl = {5'h0a, 3'(c)};
            wr(0, 8'(m_ctrl));
            ev(0);
            if (c == 0) begin
                ticks(len / 2);
                ev(0);
            end
            p0 = pcsp_hi; d0 = dev_hi;
            ticks(len - 1);
            idle(3);
            chk(8'(pcsp_hi - p0), 0);
            ticks(1);
            idle(3);
            chk({7'h0, pcsp_hi != p0}, 8'h01);
            chk({7'h0, dev_hi != d0}, 8'h01);
            m_status = 1;
            rd(3, m_status);
            rd(0, m_ctrl);
        end
        // Halt clears count and timeout; sleep overflow leaves device running
        m_ctrl = 8'h50;
        wr(0, 8'h50);
        ticks(100);
        ev(1);
        idle(2);
        chk({7'h0, sleeping_out}, 8'h01);
        m_status = 2;
        rd(3, m_status);
        p0 = pcsp_hi; d0 = dev_hi;
        ticks(255);
        idle(3);
        chk(8'(pcsp_hi - p0), 0);
        ticks(1);
        idle(3);
        chk({7'h0, pcsp_hi != p0}, 8'h01);
        chk(8'(dev_hi - d0), 0);
        m_status = 3;
        rd(3, m_status);
        ev(1);
        m_status = 2;
        ev(2);
        idle(2);
        chk({7'h0, sleeping_out}, 8'h00);
        // Random bad watchdog key
        do v = $urandom_range(0, 31); while (v == 5'h15 || v == 5'h0a);
        wr(0, {v[4:0], 3'($urandom)});
        wait_lvl(1'b1, n);
        chk({7'h0, n >= 4}, 8'h01);
        wait_lvl(1'b0, n);
        m_flags = 1; m_ctrl = 8'h53; m_pin = 8'h55;
        rd(1, m_flags);
        rd(0, m_ctrl);
        rd(2, m_pin);
        wr(1, 8'h01);
        rd(1, m_flags);
        wr(1, 8'h00);
        m_flags = 0;
        rd(1, m_flags);
        // Random bad pin code
        do v = $urandom_range(0, 255); while (v == 8'h55 || v == 8'haa);
        wr(2, v[7:0]);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        m_flags = 8;
        rd(1, m_flags);
        rd(2, m_pin);
        wr(1, 8'h00);
        m_flags = 0;
        // External reset pin
        wr(2, 8'haa);
        idle(2);
        chk({7'h0, pin_is_reset_out}, 8'h01);
        rd(2, 8'haa);
        @(posedge clock_in);
        external_reset_pin_n_in <= 1'b0;
        wait_lvl(1'b1, n);
        idle(3);
        @(posedge clock_in);
        external_reset_pin_n_in <= 1'b1;
        wait_lvl(1'b0, n);
        chk({7'h0, n >= 6}, 8'h01);
        rd(2, m_pin);
        rd(1, m_flags);
        rd(3, m_status);
        // Undervoltage
        wr(0, 8'ha8);
        @(posedge clock_in);
        undervoltage_reset_in <= 1'b1;
        wait_lvl(1'b1, n);
        idle(3);
        @(posedge clock_in);
        undervoltage_reset_in <= 1'b0;
        wait_lvl(1'b0, n);
        chk({7'h0, n >= 6}, 8'h01);
        m_flags = 4;
        rd(1, m_flags);
        rd(0, m_ctrl);
        test_done();
    end
endmodule // tb_wdrc_top
